/* cmd_unit_pkg.sv */
// constants and types shared by the encoder parameter command unit
package cmd_unit_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ_POS = 8'h42;
  localparam logic [7:0] CMD_SET_POS = 8'h43;
  localparam logic [7:0] CMD_READ_CNT = 8'h46;
  localparam logic [7:0] CMD_INC_CNT = 8'h47;
  localparam logic [7:0] CMD_CLR_CNT = 8'h49;
  localparam logic [7:0] CMD_READ_DATA = 8'h4a;
  localparam logic [7:0] CMD_STORE_DATA = 8'h4b;
  localparam logic [7:0] CMD_FIELD_STAT = 8'h4c;
  localparam logic [7:0] CMD_CREATE = 8'h4d;
  localparam logic [7:0] CMD_FREE_MEM = 8'h4e;
  localparam logic [7:0] CMD_CHG_KEY = 8'h4f;
  localparam logic [7:0] CMD_STATUS = 8'h50;
  localparam logic [7:0] CMD_TYPE = 8'h52;
  localparam logic [7:0] CMD_RESET = 8'h53;
  localparam logic [7:0] CMD_SET_ADDR = 8'h55;
  localparam logic [7:0] CMD_SERIAL = 8'h56;
  localparam logic [7:0] CMD_LINK_CFG = 8'h57;

  // ----------------------------------------------------------------
  // status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_INTEGRITY = 8'h06;
  localparam logic [7:0] ST_WATCHDOG = 8'h07;
  localparam logic [7:0] ST_PARITY = 8'h09;
  localparam logic [7:0] ST_CHECKSUM = 8'h0a;
  localparam logic [7:0] ST_UNKNOWN = 8'h0b;
  localparam logic [7:0] ST_LENGTH = 8'h0c;
  localparam logic [7:0] ST_ARG = 8'h0d;
  localparam logic [7:0] ST_PROTECTED = 8'h0e;
  localparam logic [7:0] ST_KEY = 8'h0f;
  localparam logic [7:0] ST_FIXED_SIZE = 8'h10;
  localparam logic [7:0] ST_WORD_ADDR = 8'h11;
  localparam logic [7:0] ST_NO_FIELD = 8'h12;
  localparam logic [7:0] ST_OVERSPEED = 8'h1f;

  // ----------------------------------------------------------------
  // factory defaults and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] DEF_ADDR = 8'h40;
  localparam logic [7:0] DEF_LINK_MODE = 8'he4;
  localparam logic [7:0] DEF_CODE0 = 8'h55;
  localparam logic [7:0] MEM_BYTES = 8'h80;
  localparam logic [7:0] FIELDS = 8'h04;
  localparam logic [7:0] CODE0_SEL = 8'hff;
  localparam logic [3:0] REQ_MAX = 4'h8;
  localparam logic [3:0] HDR_LEN = 4'h2;

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    EXEC = 2'b01,
    SEND = 2'b11
  } phase_t;

  // total request length: address, command, arguments, checksum
  function automatic logic [3:0] req_len(input logic [7:0] cmd);
    logic [3:0] n;
    n = 4'h0;
    case (cmd)
      CMD_READ_POS, CMD_READ_CNT, CMD_INC_CNT, CMD_FREE_MEM: n = 4'h3;
      CMD_STATUS, CMD_TYPE, CMD_RESET, CMD_SERIAL: n = 4'h3;
      CMD_CLR_CNT, CMD_FIELD_STAT: n = 4'h4;
      CMD_SET_ADDR, CMD_LINK_CFG: n = 4'h5;
      CMD_READ_DATA, CMD_CREATE, CMD_CHG_KEY: n = 4'h6;
      CMD_STORE_DATA: n = 4'h7;
      CMD_SET_POS: n = 4'h8;
      default: n = 4'h0;
    endcase
    return n;
  endfunction : req_len

endpackage : cmd_unit_pkg

/* encoder_parameter_command_unit.sv */
// command interpreter and status keeper of the encoder parameter channel
//
// Functional notes
// - no fault recorded, status read returns 00h
// - bad closing checksum rejects request, 0Ah
// - unknown command code refused, status 0Bh
// - wrong request byte count discarded, 0Ch
// - argument outside permitted set, 0Dh
// - store to protected field refused, 0Eh
// - wrong field access key refused, 0Fh
// - resizing a fixed-size field refused, 10h
// - word address beyond field refused, 11h
// - access to missing field refused, 12h
// - watchdog restart reported as status 07h
// - overspeed withholds position, status 1Fh
// - integrity check failure flags status 06h
// - guarded commands run only with matching key
// - protection key byte leaves factory as 55h
// - 56h returns serial number and firmware version
// - 57h sets link mode, default E4h
// - 55h sets bus address, default 40h
// - 4Ch returns field existence and protection
// - 4Eh returns free user memory, 128 initially
`timescale 1ns/1ps

module encoder_parameter_command_unit #(
  parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001,
  // arbitrary values, not tied to any product
  parameter logic [7:0] FW_VERSION = 8'h01,
  parameter logic [7:0] TYPE_ID = 8'h5a
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_parity_err,
  input wire logic rx_end,
  input wire logic tx_ready,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic [26:0] raw_position,
  input wire logic overspeed,
  input wire logic integrity_fail,
  input wire logic watchdog_restart,
  output logic [7:0] status_code,
  output logic [7:0] bus_address,
  output logic [7:0] link_mode,
  output logic busy
);
  import cmd_unit_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_t phase;
    logic [7:0][7:0] req;
    logic [3:0] cnt;
    logic par_bad;
    logic [7:0] status;
    logic [7:0] code0;
    logic [7:0] addr;
    logic [7:0] mode;
    logic [26:0] pos_off;
    logic [31:0] counter;
    logic [127:0][7:0] mem;
    logic [3:0] f_exist;
    logic [3:0] f_wp;
    logic [3:0][6:0] f_base;
    logic [3:0][6:0] f_size;
    logic [3:0][7:0] f_key;
    logic [7:0] free;
    logic [7:0][7:0] resp;
    logic [3:0] resp_len;
    logic [7:0] chk;
    logic [3:0] tx_idx;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic started;
  } state_t;

  state_t s;
  state_t next_s;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] cmd;
    logic [7:0] err;
    logic [7:0] x;
    logic [1:0] f;
    logic [7:0] a2;
    logic [7:0] a3;
    logic [7:0] a4;
    logic [26:0] pos;
    logic [6:0] idx;
    cmd = s.req[1];
    err = ST_OK;
    x = 8'h00;
    f = s.req[2][1:0];
    a2 = s.req[2];
    a3 = s.req[3];
    a4 = s.req[4];
    pos = raw_position + s.pos_off;
    idx = 7'h00;
    next_s = s;

    unique case (s.phase)
      IDLE: begin
        // requests only collect here; the link is half duplex
        if (rx_valid) begin
          if (s.cnt < REQ_MAX) begin
            next_s.req[s.cnt[2:0]] = rx_byte;
          end
          if (s.cnt != 4'hf) begin
            next_s.cnt = s.cnt + 4'h1;
          end
        end
        if (rx_parity_err) begin
          next_s.par_bad = 1'b1;
        end
        if (rx_end && s.cnt != 4'h0) begin
          next_s.phase = EXEC;
        end else if (rx_end) begin
          next_s.par_bad = 1'b0;
        end
      end

      EXEC: begin
        for (int i = 0; i < 8; i++) begin
          if (4'(i) < s.cnt) begin
            x = x ^ s.req[i];
          end
        end
        next_s.resp = '0;
        next_s.resp[0] = s.addr;
        next_s.resp[1] = cmd;
        next_s.resp_len = HDR_LEN;

        if (s.par_bad) begin
          err = ST_PARITY;
        end else if (s.cnt > REQ_MAX || x != 8'h00) begin
          err = ST_CHECKSUM;
        end else if (req_len(cmd) == 4'h0) begin
          err = ST_UNKNOWN;
        end else if (s.cnt != req_len(cmd)) begin
          err = ST_LENGTH;
        end else begin
          case (cmd)
            CMD_READ_POS: begin
              if (overspeed) begin
                err = ST_OVERSPEED;
              end else begin
                next_s.resp[2] = {5'h00, pos[26:24]};
                next_s.resp[3] = pos[23:16];
                next_s.resp[4] = pos[15:8];
                next_s.resp[5] = pos[7:0];
                next_s.resp_len = 4'h6;
              end
            end
            CMD_SET_POS: begin
              if (a2 != s.code0) begin
                err = ST_KEY;
              end else begin
                next_s.pos_off = {a3[2:0], a4, s.req[5], s.req[6]}
                                 - raw_position;
              end
            end
            CMD_READ_CNT: begin
              next_s.resp[2] = s.counter[31:24];
              next_s.resp[3] = s.counter[23:16];
              next_s.resp[4] = s.counter[15:8];
              next_s.resp[5] = s.counter[7:0];
              next_s.resp_len = 4'h6;
            end
            CMD_INC_CNT: begin
              next_s.counter = s.counter + 32'h0000_0001;
            end
            CMD_CLR_CNT: begin
              if (a2 != s.code0) begin
                err = ST_KEY;
              end else begin
                next_s.counter = '0;
              end
            end
            CMD_READ_DATA, CMD_STORE_DATA: begin
              idx = s.f_base[f] + a3[6:0];
              if (a2 >= FIELDS) begin
                err = ST_ARG;
              end else if (!s.f_exist[f]) begin
                err = ST_NO_FIELD;
              end else if (a4 != s.f_key[f]) begin
                err = ST_KEY;
              end else if (a3 >= {1'b0, s.f_size[f]}) begin
                err = ST_WORD_ADDR;
              end else if (cmd == CMD_READ_DATA) begin
                next_s.resp[2] = s.mem[idx];
                next_s.resp_len = 4'h3;
              end else if (s.f_wp[f]) begin
                err = ST_PROTECTED;
              end else begin
                next_s.mem[idx] = s.req[5];
              end
            end
            CMD_FIELD_STAT: begin
              if (a2 >= FIELDS) begin
                err = ST_ARG;
              end else begin
                next_s.resp[2] = {s.f_exist[f], s.f_wp[f], 6'h00};
                next_s.resp[3] = {1'b0, s.f_size[f]};
                next_s.resp_len = 4'h4;
              end
            end
            CMD_CREATE: begin
              // fields are carved in order; size cannot change later
              if (a2 >= FIELDS || a3[6:0] == 7'h00) begin
                err = ST_ARG;
              end else if (s.f_exist[f]) begin
                err = ST_FIXED_SIZE;
              end else if ({1'b0, a3[6:0]} > s.free) begin
                err = ST_ARG;
              end else begin
                next_s.f_exist[f] = 1'b1;
                next_s.f_wp[f] = a3[7];
                next_s.f_size[f] = a3[6:0];
                next_s.f_base[f] = 7'(MEM_BYTES - s.free);
                next_s.f_key[f] = a4;
                next_s.free = s.free - {1'b0, a3[6:0]};
              end
            end
            CMD_FREE_MEM: begin
              next_s.resp[2] = s.free;
              next_s.resp_len = 4'h3;
            end
            CMD_CHG_KEY: begin
              if (a2 == CODE0_SEL) begin
                if (a3 != s.code0) begin
                  err = ST_KEY;
                end else begin
                  next_s.code0 = a4;
                end
              end else if (a2 >= FIELDS) begin
                err = ST_ARG;
              end else if (!s.f_exist[f]) begin
                err = ST_NO_FIELD;
              end else if (a3 != s.f_key[f]) begin
                err = ST_KEY;
              end else begin
                next_s.f_key[f] = a4;
              end
            end
            CMD_STATUS: begin
              // reading the code also clears it
              next_s.resp[2] = s.status;
              next_s.resp_len = 4'h3;
              next_s.status = ST_OK;
            end
            CMD_TYPE: begin
              next_s.resp[2] = TYPE_ID;
              next_s.resp_len = 4'h3;
            end
            CMD_RESET: begin
              next_s.status = ST_OK;
            end
            CMD_SET_ADDR: begin
              if (a3 != s.code0) begin
                err = ST_KEY;
              end else begin
                next_s.addr = a2;
              end
            end
            CMD_SERIAL: begin
              next_s.resp[2] = SERIAL_NUMBER[31:24];
              next_s.resp[3] = SERIAL_NUMBER[23:16];
              next_s.resp[4] = SERIAL_NUMBER[15:8];
              next_s.resp[5] = SERIAL_NUMBER[7:0];
              next_s.resp[6] = FW_VERSION;
              next_s.resp_len = 4'h7;
            end
            CMD_LINK_CFG: begin
              if (a3 != s.code0) begin
                err = ST_KEY;
              end else begin
                next_s.mode = a2;
              end
            end
            default: begin
              err = ST_UNKNOWN;
            end
          endcase
        end

        // the checksum trails the answer: xor of every answer byte
        next_s.chk = 8'h00;
        for (int i = 0; i < 8; i++) begin
          next_s.chk = next_s.chk ^ next_s.resp[i];
        end
        next_s.cnt = 4'h0;
        next_s.par_bad = 1'b0;
        next_s.tx_idx = 4'h0;
        if (s.cnt == 4'h0 || s.req[0] != s.addr) begin
          // another node's request: no answer and no error code, but its command still runs; 50h and 53h clear status
          next_s.phase = IDLE;
        end else if (err != ST_OK) begin
          // a refused request is silent; the code waits for 50h or 53h
          next_s.status = err;
          next_s.phase = IDLE;
        end else begin
          next_s.phase = SEND;
        end
      end

      SEND: begin
        if (!s.tx_valid || tx_ready) begin
          if (s.tx_idx <= s.resp_len) begin
            next_s.tx_valid = 1'b1;
            if (s.tx_idx == s.resp_len) begin
              next_s.tx_byte = s.chk;
            end else begin
              next_s.tx_byte = s.resp[s.tx_idx[2:0]];
            end
            next_s.tx_idx = s.tx_idx + 4'h1;
          end else begin
            next_s.tx_valid = 1'b0;
            next_s.phase = IDLE;
          end
        end
      end
    endcase

    // ----------------------------------------------------------------
    // device events: placed last so a set beats a same-cycle clear
    // ----------------------------------------------------------------
    if (!s.started) begin
      next_s.started = 1'b1;
      if (watchdog_restart) begin
        next_s.status = ST_WATCHDOG;
      end
    end
    if (integrity_fail) begin
      next_s.status = ST_INTEGRITY;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.phase <= IDLE;
      s.status <= ST_OK;
      s.code0 <= DEF_CODE0;
      s.addr <= DEF_ADDR;
      s.mode <= DEF_LINK_MODE;
      s.free <= MEM_BYTES;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign tx_byte = s.tx_byte;
  assign tx_valid = s.tx_valid;
  assign status_code = s.status;
  assign bus_address = s.addr;
  assign link_mode = s.mode;
  assign busy = s.phase[0];

endmodule : encoder_parameter_command_unit

/* cmd_unit_monitor.sv */
// port checker for the encoder parameter command unit
`timescale 1ns/1ps

module cmd_unit_monitor
  import cmd_unit_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_parity_err,
  input wire logic rx_end,
  input wire logic tx_ready,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic [26:0] raw_position,
  input wire logic overspeed,
  input wire logic integrity_fail,
  input wire logic watchdog_restart,
  input wire logic [7:0] status_code,
  input wire logic [7:0] bus_address,
  input wire logic [7:0] link_mode,
  input wire logic busy
);
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  a_reset_values: assert property (disable iff (1'b0)
    !rstn |-> bus_address == DEF_ADDR && link_mode == DEF_LINK_MODE
    && status_code == ST_OK) else $error("reset values wrong");
  a_busy_cause: assert property ($rose(busy) |-> $past(rx_end))
    else $error("busy rose without a finished request");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:200] !busy)
    else $error("unit stayed busy too long");
  a_answer_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("answer byte dropped before acceptance");
  a_valid_busy: assert property (tx_valid |-> busy)
    else $error("answer byte outside a busy phase");
  // an address change takes effect with its own command, so the answer
  // carries the address that was in force when the request closed
  logic [7:0] lead_addr;
  always_ff @(posedge clock) begin
    if (rx_end && !busy) begin
      lead_addr <= bus_address;
    end
  end

  a_answer_lead: assert property (
    $rose(tx_valid) |-> tx_byte == lead_addr)
    else $error("answer does not start with the address");
  a_integrity_flag: assert property (
    integrity_fail |=> status_code == ST_INTEGRITY)
    else $error("integrity failure not flagged");
  a_watchdog_flag: assert property (
    $rose(rstn) && watchdog_restart |=> status_code == ST_WATCHDOG)
    else $error("watchdog restart not flagged");
  a_link_guard: assert property (
    $changed(link_mode) |-> $past(busy))
    else $error("link mode changed outside a command");
  a_addr_guard: assert property (
    $changed(bus_address) |-> $past(busy))
    else $error("address changed outside a command");

  c_answer: cover property ($rose(tx_valid));
  c_stall: cover property (tx_valid && !tx_ready);
  c_key_refused: cover property (status_code == ST_KEY);
endmodule : cmd_unit_monitor

bind encoder_parameter_command_unit cmd_unit_monitor mon_u (.clock, .rstn,
  .rx_byte, .rx_valid, .rx_parity_err, .rx_end, .tx_ready, .tx_byte,
  .tx_valid, .raw_position, .overspeed, .integrity_fail, .watchdog_restart,
  .status_code, .bus_address, .link_mode, .busy);

/* master_model.sv */
// drive controller model: sends requests and collects answer bytes
`timescale 1ns/1ps

module master_model (
  input wire logic clock,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_parity_err,
  output logic rx_end,
  output logic tx_ready
);
  logic [7:0] ans[$];
  logic slow = 1'b0;

  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_parity_err = 1'b0;
    rx_end = 1'b0;
    tx_ready = 1'b1;
  end

  // a slow master accepts only every other cycle
  always @(negedge clock) tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clock) if (tx_valid && tx_ready) ans.push_back(tx_byte);

  task automatic send(input logic [7:0] q[$], input bit bad_chk,
                      input bit bad_par);
    logic [7:0] c;
    c = 8'h00;
    foreach (q[i]) c ^= q[i];
    q.push_back(bad_chk ? ~c : c);
    ans.delete();
    foreach (q[i]) begin
      @(negedge clock);
      rx_byte <= q[i];
      rx_valid <= 1'b1;
      rx_parity_err <= bad_par && i == 1;
      @(negedge clock);
      rx_valid <= 1'b0;
      rx_parity_err <= 1'b0;
      rx_byte <= ~q[i]; // an idle line must not repeat the last byte
    end
    @(negedge clock);
    rx_end <= 1'b1;
    @(negedge clock);
    rx_end <= 1'b0;
  endtask : send
endmodule : master_model

/* test_encoder_parameter_command_unit.sv */
// self-checking bench for the encoder parameter command unit
`timescale 1ns/1ps

module test_encoder_parameter_command_unit;
  import cmd_unit_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b1;
  logic [26:0] raw_position = 27'h0;
  logic overspeed = 1'b0;
  logic integrity_fail = 1'b0;
  logic watchdog_restart = 1'b0;
  logic [7:0] rx_byte, tx_byte, status_code, bus_address, link_mode;
  logic rx_valid, rx_parity_err, rx_end, tx_ready, tx_valid, busy;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  always #25 clock = ~clock;

  master_model m (.clock, .tx_byte, .tx_valid, .rx_byte, .rx_valid,
    .rx_parity_err, .rx_end, .tx_ready);
  encoder_parameter_command_unit dut_u (.clock, .rstn, .rx_byte, .rx_valid,
    .rx_parity_err, .rx_end, .tx_ready, .tx_byte, .tx_valid, .raw_position,
    .overspeed, .integrity_fail, .watchdog_restart, .status_code,
    .bus_address, .link_mode, .busy);

  // --------------------------------------------------------------
  // shared helpers
  // --------------------------------------------------------------
  task automatic give_verdict;
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // a hang is cut short here rather than in each wait loop
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic run(input logic [7:0] q[$], input bit bad_chk = 1'b0,
                     input bit bad_par = 1'b0);
    m.send(q, bad_chk, bad_par);
    repeat (3) @(negedge clock);
    while (busy !== 1'b0) @(negedge clock);
  endtask : run

  task automatic ask(input logic [7:0] q[$], input logic [7:0] d[$]);
    logic [7:0] e[$];
    logic [7:0] c;
    e = '{q[0], q[1]};
    e = {e, d};
    c = 8'h00;
    foreach (e[i]) c ^= e[i];
    e.push_back(c);
    run(q);
    check(8'(m.ans.size()), 8'(e.size()));
    foreach (e[i]) check(i < m.ans.size() ? m.ans[i] : 8'hxx, e[i]);
  endtask : ask

  task automatic stat(input logic [7:0] exp);
    ask('{8'h40, CMD_STATUS}, '{exp});
  endtask : stat

  task automatic err(input logic [7:0] q[$], input bit bc, input bit bp,
                     input logic [7:0] exp);
    run(q, bc, bp);
    check(8'(m.ans.size()), 8'h00);
    stat(exp);
  endtask : err

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_defaults;
    check(bus_address, DEF_ADDR);
    check(link_mode, DEF_LINK_MODE);
    stat(ST_OK);
    ask('{8'h40, CMD_FREE_MEM}, '{MEM_BYTES});
    ask('{8'h40, CMD_SERIAL},
        '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01});
  endtask : t_defaults

  task automatic t_refusals;
    err('{8'h40, 8'h44}, 0, 0, ST_UNKNOWN);
    err('{8'h40, CMD_STATUS, 8'h00}, 0, 0, ST_LENGTH);
    err('{8'h40, CMD_STATUS}, 1, 0, ST_CHECKSUM);
    err('{8'h40, CMD_STATUS}, 0, 1, ST_PARITY);
    err('{8'h40, CMD_CREATE, 8'h00, 8'h00, 8'h33}, 0, 0, ST_ARG);
  endtask : t_refusals

  task automatic t_key;
    err('{8'h40, CMD_SET_ADDR, 8'h41, 8'h54}, 0, 0, ST_KEY);
    check(bus_address, DEF_ADDR);
    run('{8'h40, CMD_SET_ADDR, 8'h41, DEF_CODE0});
    check(bus_address, 8'h41);
    run('{8'h41, CMD_SET_ADDR, 8'h40, DEF_CODE0});
    run('{8'h40, CMD_LINK_CFG, 8'he5, DEF_CODE0});
    check(link_mode, 8'he5);
    err('{8'h40, CMD_CLR_CNT, 8'h54}, 0, 0, ST_KEY);
  endtask : t_key

  task automatic t_fields;
    err('{8'h40, CMD_READ_DATA, 8'h00, 8'h00, 8'h33}, 0, 0,
        ST_NO_FIELD);
    run('{8'h40, CMD_CREATE, 8'h00, 8'h02, 8'h33});
    ask('{8'h40, CMD_FIELD_STAT, 8'h00}, '{8'h80, 8'h02});
    ask('{8'h40, CMD_FREE_MEM}, '{8'h7e});
    err('{8'h40, CMD_CREATE, 8'h00, 8'h03, 8'h33}, 0, 0,
        ST_FIXED_SIZE);
    err('{8'h40, CMD_STORE_DATA, 8'h00, 8'h02, 8'h33, 8'h5a}, 0, 0,
        ST_WORD_ADDR);
    err('{8'h40, CMD_STORE_DATA, 8'h00, 8'h01, 8'h34, 8'h5a}, 0, 0,
        ST_KEY);
    run('{8'h40, CMD_STORE_DATA, 8'h00, 8'h01, 8'h33, 8'ha5});
    ask('{8'h40, CMD_READ_DATA, 8'h00, 8'h01, 8'h33}, '{8'ha5});
    run('{8'h40, CMD_CREATE, 8'h01, 8'h81, 8'h33});
    ask('{8'h40, CMD_FIELD_STAT, 8'h01}, '{8'hc0, 8'h01});
    err('{8'h40, CMD_STORE_DATA, 8'h01, 8'h00, 8'h33, 8'h11}, 0, 0,
        ST_PROTECTED);
  endtask : t_fields

  task automatic t_position;
    raw_position = 27'h5abcdef;
    m.slow = 1'b1;
    ask('{8'h40, CMD_READ_POS}, '{8'h05, 8'hab, 8'hcd, 8'hef});
    m.slow = 1'b0;
    overspeed = 1'b1;
    err('{8'h40, CMD_READ_POS}, 0, 0, ST_OVERSPEED);
    overspeed = 1'b0;
  endtask : t_position

  task automatic t_misc;
    ask('{8'h40, CMD_TYPE}, '{8'h5a});
    run('{8'h40, CMD_INC_CNT});
    ask('{8'h40, CMD_READ_CNT}, '{8'h00, 8'h00, 8'h00, 8'h01});
    run('{8'h40, CMD_SET_POS, DEF_CODE0, 8'h01, 8'h23, 8'h45,
          8'h67});
    ask('{8'h40, CMD_READ_POS}, '{8'h01, 8'h23, 8'h45, 8'h67});
    run('{8'h40, CMD_CHG_KEY, CODE0_SEL, DEF_CODE0, 8'h66});
    err('{8'h40, CMD_CLR_CNT, DEF_CODE0}, 0, 0, ST_KEY);
    run('{8'h40, CMD_CLR_CNT, 8'h66});
    ask('{8'h40, CMD_READ_CNT}, '{8'h00, 8'h00, 8'h00, 8'h00});
    run('{8'h40, CMD_CHG_KEY, CODE0_SEL, 8'h66, DEF_CODE0});
    run('{8'h40, CMD_CHG_KEY, 8'h00, 8'h33, 8'h44});
    ask('{8'h40, CMD_READ_DATA, 8'h00, 8'h01, 8'h44}, '{8'ha5});
    run('{8'h40, 8'h44});
    check(status_code, ST_UNKNOWN);
    run('{8'h40, CMD_RESET});
    stat(ST_OK);
  endtask : t_misc

  task automatic t_events;
    integrity_fail = 1'b1;
    @(negedge clock);
    integrity_fail = 1'b0;
    check(status_code, ST_INTEGRITY);
    stat(ST_INTEGRITY);
    stat(ST_OK);
    watchdog_restart = 1'b1;
    rstn = 1'b0;
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    watchdog_restart = 1'b0;
    check(link_mode, DEF_LINK_MODE);
    stat(ST_WATCHDOG);
  endtask : t_events

  initial begin
    // a real falling edge puts the unit in reset before the first clock
    #1 rstn = 1'b0;
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    t_defaults();
    t_refusals();
    t_key();
    t_fields();
    t_position();
    t_misc();
    t_events();
    give_verdict();
  end
endmodule : test_encoder_parameter_command_unit
